// *** rtl/lnsb_top.sv ***
// lin node setup registers, indirect access, checksum unit and bit-rate generator
`timescale 1ns/1ps
`include "lnsb_regs.svh"

module lnsb_top (
  input  wire logic              clock_in,
  input  wire logic              arst_n_in,
  // core register port
  input  wire lnsb_pkg::lnsb_sel_t cpu_sel_in,
  input  wire logic              cpu_wr_in,
  input  wire logic              cpu_rd_in,
  input  wire logic [7:0]        cpu_wdata_in,
  output logic      [7:0]        cpu_rdata_out,
  // events from the frame engine
  input  wire logic              frame_irq_event_in,
  input  wire logic              frame_err_event_in,
  // checksum byte stream
  input  wire logic              cks_clear_in,
  input  wire logic [7:0]        cks_id_in,
  input  wire logic              cks_byte_valid_in,
  input  wire logic              cks_check_in,
  input  wire logic [7:0]        cks_byte_in,
  output logic      [7:0]        cks_value_out,
  output logic                   cks_err_out,
  // configuration and status toward the frame engine
  output logic                   lin_enable_out,
  output logic                   master_mode_out,
  output logic                   auto_bit_rate_select_out,
  output logic                   enhanced_cksum_out,
  output logic      [7:0]        frame_ctrl_out,
  output logic      [3:0]        frame_length_out,
  output logic                   irq_out,
  output logic                   err_pending_out,
  output logic                   bit_tick_out
);
  import lnsb_pkg::*;

  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  logic rst_meta_ff;
  logic rst_n_ff;

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff    <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff    <= rst_meta_ff;
    end
  end

  // ------------------------------------------------------------
  // register storage
  // ------------------------------------------------------------
  logic [7:0]      mode_cfg_ff;
  logic [7:0]      index_ff;
  logic [7:0]      ctrl_ff;
  logic [7:0]      size_ff;
  logic [7:0]      div_low_ff;
  logic [7:0]      scale_ff;
  logic            irq_pend_ff;
  logic            err_pend_ff;
  logic [7:0]      cks_sum_ff;
  logic            cks_fail;
  logic            win_wr;
  logic            ctrl_wr;
  logic            timing_wr;
  logic            auto_mode;
  logic [4:0]      eff_mult;
  lnsb_cks_state_t cks_state_ff;

  // true when the held index names the given internal register
  function automatic logic idx_is(input logic [7:0] idx, input logic [7:0] reg_idx);
    idx_is = (idx == reg_idx);
  endfunction

  // read value of the internal register currently indexed
  function automatic logic [7:0] window_value(input logic [7:0] idx);
    logic [7:0] v;
    v = 8'h00;
    if (idx_is(idx, `LNSB_IDX_FRAME_CONTROL)) begin
      v = ctrl_ff;
      v[`LNSB_CTRL_RSTINT_BIT] = irq_pend_ff;
      v[`LNSB_CTRL_RSTERR_BIT] = err_pend_ff;
    end else if (idx_is(idx, `LNSB_IDX_FRAME_LENGTH)) begin
      v = size_ff;
    end else if (idx_is(idx, `LNSB_IDX_DIVIDER_LOW)) begin
      v = div_low_ff;
    end else if (idx_is(idx, `LNSB_IDX_SCALE)) begin
      v = scale_ff;
    end
    window_value = v;
  endfunction

  assign win_wr    = cpu_wr_in && (cpu_sel_in == LNSB_SEL_WINDOW); // [RL4]
  assign ctrl_wr   = win_wr && idx_is(index_ff, `LNSB_IDX_FRAME_CONTROL); // [RL5]
  assign timing_wr = win_wr && (idx_is(index_ff, `LNSB_IDX_DIVIDER_LOW)
                                || idx_is(index_ff, `LNSB_IDX_SCALE));

  // ------------------------------------------------------------
  // direct registers
  // ------------------------------------------------------------
  always_ff @(posedge clock_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      mode_cfg_ff <= `LNSB_RST_BYTE;
    end else if (cpu_wr_in && (cpu_sel_in == LNSB_SEL_MODE)) begin
      mode_cfg_ff <= cpu_wdata_in & `LNSB_CFG_MASK; // [RL1] [RL2] [RL11]
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      index_ff <= `LNSB_RST_BYTE;
    end else if (cpu_wr_in && (cpu_sel_in == LNSB_SEL_INDEX)) begin
      index_ff <= cpu_wdata_in; // [RL4]
    end
  end

  // ------------------------------------------------------------
  // indirect registers
  // ------------------------------------------------------------
  always_ff @(posedge clock_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      ctrl_ff <= `LNSB_RST_BYTE;
    end else if (ctrl_wr) begin
      // flag-reset bits act and are not stored
      ctrl_ff <= cpu_wdata_in & `LNSB_CTRL_STORE_MASK; // [RL5]
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      size_ff <= `LNSB_RST_BYTE;
    end else if (win_wr && idx_is(index_ff, `LNSB_IDX_FRAME_LENGTH)) begin
      size_ff <= cpu_wdata_in; // [RL5] [RL10]
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      div_low_ff <= `LNSB_RST_BYTE;
      scale_ff   <= `LNSB_RST_BYTE;
    end else if (win_wr) begin
      if (idx_is(index_ff, `LNSB_IDX_DIVIDER_LOW)) begin
        div_low_ff <= cpu_wdata_in; // [RL12]
      end
      if (idx_is(index_ff, `LNSB_IDX_SCALE)) begin
        scale_ff <= cpu_wdata_in; // [RL12]
      end
    end
  end

  // ------------------------------------------------------------
  // core read data
  // ------------------------------------------------------------
  always_ff @(posedge clock_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      cpu_rdata_out <= 8'h00;
    end else if (cpu_rd_in) begin
      case (cpu_sel_in)
        LNSB_SEL_MODE:   cpu_rdata_out <= mode_cfg_ff;
        LNSB_SEL_INDEX:  cpu_rdata_out <= index_ff;
        LNSB_SEL_WINDOW: cpu_rdata_out <= window_value(index_ff); // [RL5] [RL14]
        default:         cpu_rdata_out <= 8'h00;
      endcase
    end
  end

  // ------------------------------------------------------------
  // pending flags
  // ------------------------------------------------------------
  // a new event in the clearing cycle wins so nothing is lost
  always_ff @(posedge clock_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      err_pend_ff <= 1'b0;
    end else if (frame_err_event_in || cks_fail) begin
      err_pend_ff <= 1'b1; // [RL14]
    end else if (ctrl_wr && cpu_wdata_in[`LNSB_CTRL_RSTERR_BIT]) begin
      err_pend_ff <= 1'b0; // [RL13]
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      irq_pend_ff <= 1'b0;
    end else if (frame_irq_event_in || frame_err_event_in || cks_fail) begin
      irq_pend_ff <= 1'b1; // [RL14]
    end else if (ctrl_wr && cpu_wdata_in[`LNSB_CTRL_RSTINT_BIT]) begin
      irq_pend_ff <= 1'b0; // [RL13]
    end
  end

  // ------------------------------------------------------------
  // checksum unit
  // ------------------------------------------------------------
  logic [8:0] add_raw;
  logic [7:0] add_fold;

  // carry-wrapping byte sum, the lin checksum is its inverse
  assign add_raw  = {1'b0, cks_sum_ff} + {1'b0, cks_byte_in};
  assign add_fold = add_raw[7:0] + {7'h00, add_raw[8]}; // [RL9]
  assign cks_fail = (cks_state_ff == LNSB_CKS_RUN) && cks_check_in
                    && (add_fold != `LNSB_CKS_GOOD); // [RL9]

  always_ff @(posedge clock_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      cks_state_ff <= LNSB_CKS_IDLE;
      cks_sum_ff   <= 8'h00;
    end else if (cks_clear_in) begin
      cks_state_ff <= LNSB_CKS_RUN;
      // enhanced sums begin with the protected identifier
      cks_sum_ff   <= size_ff[`LNSB_SIZE_ENH_BIT] ? cks_id_in : 8'h00; // [RL10] [RL9]
    end else begin
      case (cks_state_ff)
        LNSB_CKS_IDLE: cks_sum_ff <= cks_sum_ff;
        LNSB_CKS_RUN: begin
          if (cks_check_in) begin
            cks_state_ff <= LNSB_CKS_IDLE;
          end else if (cks_byte_valid_in) begin
            cks_sum_ff <= add_fold; // [RL9]
          end
        end
        default: cks_state_ff <= LNSB_CKS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      cks_err_out <= 1'b0;
    end else if (cks_clear_in) begin
      cks_err_out <= 1'b0;
    end else if (cks_fail) begin
      cks_err_out <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // bit-rate generator
  // ------------------------------------------------------------
  assign auto_mode = mode_cfg_ff[`LNSB_CFG_AUTO_BIT];
  // in automatic mode only prescaler and divider set the rate
  assign eff_mult  = auto_mode ? 5'h00
                     : scale_ff[`LNSB_SCALE_MUL_HI:`LNSB_SCALE_MUL_LO]; // [RL2]

  // counters restart on any timing write so a new rate starts clean
  lnsb_baud_gen #(
    .PRE_W (2),
    .DIV_W (9),
    .MUL_W (5)
  ) u_baud (
    .clock_in      (clock_in),
    .rst_n_in      (rst_n_ff),
    .enable_in     (mode_cfg_ff[`LNSB_CFG_ENABLE_BIT]),
    .restart_in    (timing_wr),
    .prescaler_in  (scale_ff[`LNSB_SCALE_PRE_HI:`LNSB_SCALE_PRE_LO]),
    .divider_in    ({scale_ff[`LNSB_SCALE_DIV8_BIT], div_low_ff}),
    .multiplier_in (eff_mult),
    .tick_out      (bit_tick_out)
  ); // [RL6] [RL12] [RL11]

  // ------------------------------------------------------------
  // configuration and status outputs
  // ------------------------------------------------------------
  always_ff @(posedge clock_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      lin_enable_out           <= 1'b0;
      master_mode_out          <= 1'b0;
      auto_bit_rate_select_out <= 1'b0;
      enhanced_cksum_out       <= 1'b0;
      frame_ctrl_out           <= 8'h00;
      frame_length_out         <= 4'h0;
      irq_out                  <= 1'b0;
      err_pending_out          <= 1'b0;
      cks_value_out            <= 8'hff;
    end else begin
      lin_enable_out           <= mode_cfg_ff[`LNSB_CFG_ENABLE_BIT]; // [RL11]
      master_mode_out          <= mode_cfg_ff[`LNSB_CFG_MASTER_BIT]; // [RL1]
      auto_bit_rate_select_out <= auto_mode; // [RL2]
      enhanced_cksum_out       <= size_ff[`LNSB_SIZE_ENH_BIT]; // [RL10]
      frame_ctrl_out           <= ctrl_ff;
      frame_length_out         <= size_ff[3:0];
      irq_out                  <= irq_pend_ff; // [RL14]
      err_pending_out          <= err_pend_ff; // [RL14]
      cks_value_out            <= ~cks_sum_ff; // [RL9]
    end
  end

endmodule

// *** rtl/lnsb_regs.svh ***
// register offsets, field positions, reset values and limits of the lin setup block
// Behaviour
// (RL1) mode config bit 6 picks bus master or bus slave operation
// (RL2) mode config bit 5 picks manual timing or automatic bit-rate detection
// (RL3) software uses manual timing as master; auto only as slave
// (RL4) only mode config is direct; others go through index and window
// (RL5) window access hits the internal register named by the index
// (RL6) manual rate is clock / (2^(pre+1) * divider * (mult+1))
// (RL7) software keeps prescaler 0..3, multiplier 0..31, divider 200..511
// (RL8) system keeps the core clock at or above 8 MHz
// (RL9) classic and enhanced checksums are computed and checked in hardware
// (RL10) frame length register bit 7 set selects enhanced checksum
// (RL11) mode config bit 7 enables the controller, bit 6 makes master
// (RL12) scale holds prescaler 7:6, multiplier 5:1, divider bit 8 in 0
// (RL13) writing control with both flag-reset bits clears errors and interrupt
// (RL14) status is reported for interrupt service or for polling
// (RL15) cascaded reloading counters give one tick per programmed bit time
`ifndef LNSB_REGS_SVH
`define LNSB_REGS_SVH

// ------------------------------------------------------------
// indirect register indices
// ------------------------------------------------------------
`define LNSB_IDX_FRAME_CONTROL  8'h08
`define LNSB_IDX_FRAME_LENGTH   8'h0b
`define LNSB_IDX_DIVIDER_LOW    8'h0c
`define LNSB_IDX_SCALE          8'h0d

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define LNSB_CFG_ENABLE_BIT     7
`define LNSB_CFG_MASTER_BIT     6
`define LNSB_CFG_AUTO_BIT       5
`define LNSB_CTRL_RSTINT_BIT    3
`define LNSB_CTRL_RSTERR_BIT    2
`define LNSB_SIZE_ENH_BIT       7
`define LNSB_SCALE_PRE_HI       7
`define LNSB_SCALE_PRE_LO       6
`define LNSB_SCALE_MUL_HI       5
`define LNSB_SCALE_MUL_LO       1
`define LNSB_SCALE_DIV8_BIT     0

// ------------------------------------------------------------
// reset values, masks, good checksum value and core clock limit
// ------------------------------------------------------------
`define LNSB_RST_BYTE           8'h00
`define LNSB_CFG_MASK           8'he0
`define LNSB_CTRL_STORE_MASK    8'hf3
`define LNSB_CKS_GOOD           8'hff
`define LNSB_MIN_CORE_CLK_HZ    8000000

`endif

// *** rtl/lnsb_pkg.sv ***
// types shared by the lin setup and bit-rate block
package lnsb_pkg;

  // which core-visible register a core access targets
  typedef enum logic [1:0] {
    LNSB_SEL_MODE,
    LNSB_SEL_INDEX,
    LNSB_SEL_WINDOW,
    LNSB_SEL_NONE
  } lnsb_sel_t;

  // checksum accumulator state
  typedef enum logic {
    LNSB_CKS_IDLE,
    LNSB_CKS_RUN
  } lnsb_cks_state_t;

endpackage

// *** rtl/lnsb_baud_gen.sv ***
// cascaded prescaler, divider and multiplier counters giving one bit-time tick
`timescale 1ns/1ps
`include "lnsb_regs.svh"

module lnsb_baud_gen #(
  parameter int PRE_W = 2,
  parameter int DIV_W = 9,
  parameter int MUL_W = 5
) (
  input  wire logic             clock_in,
  input  wire logic             rst_n_in,
  input  wire logic             enable_in,
  input  wire logic             restart_in,
  input  wire logic [PRE_W-1:0] prescaler_in,
  input  wire logic [DIV_W-1:0] divider_in,
  input  wire logic [MUL_W-1:0] multiplier_in,
  output logic                  tick_out
);

  logic [3:0]       pre_cnt_ff;
  logic [DIV_W-1:0] div_cnt_ff;
  logic [MUL_W-1:0] mul_cnt_ff;
  logic [3:0]       pre_last;
  logic [DIV_W-1:0] div_last;
  logic             pre_wrap;
  logic             div_wrap;

  // 2^(pre+1) core clocks per prescale step
  assign pre_last = 4'hf >> (2'h3 - prescaler_in);
  // a divider of zero wraps to the full count rather than stalling
  assign div_last = divider_in - {{(DIV_W-1){1'b0}}, 1'b1};
  assign pre_wrap = (pre_cnt_ff == pre_last);
  assign div_wrap = pre_wrap && (div_cnt_ff == div_last);

  // ------------------------------------------------------------
  // counter cascade
  // ------------------------------------------------------------
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pre_cnt_ff <= 4'h0;
      div_cnt_ff <= '0;
      mul_cnt_ff <= '0;
    end else if (!enable_in || restart_in) begin
      pre_cnt_ff <= 4'h0;
      div_cnt_ff <= '0;
      mul_cnt_ff <= '0;
    end else begin
      pre_cnt_ff <= pre_wrap ? 4'h0 : pre_cnt_ff + 4'h1; // [RL15] [RL6]
      if (pre_wrap) begin
        div_cnt_ff <= div_wrap ? '0 : div_cnt_ff + {{(DIV_W-1){1'b0}}, 1'b1}; // [RL15]
      end
      if (div_wrap) begin
        mul_cnt_ff <= (mul_cnt_ff == multiplier_in) ? '0
                      : mul_cnt_ff + {{(MUL_W-1){1'b0}}, 1'b1}; // [RL15]
      end
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tick_out <= 1'b0;
    end else begin
      tick_out <= enable_in && !restart_in && div_wrap && (mul_cnt_ff == multiplier_in); // [RL6]
    end
  end

endmodule

// *** tb/lnsb_top_properties.sv ***
// concurrent checks on the ports of the lin setup block
`timescale 1ns/1ps
module lnsb_top_props (
  input wire logic                clock_in,
  input wire logic                arst_n_in,
  input wire lnsb_pkg::lnsb_sel_t cpu_sel_in,
  input wire logic                cpu_wr_in,
  input wire logic                cpu_rd_in,
  input wire logic [7:0]          cpu_wdata_in,
  input wire logic [7:0]          cpu_rdata_out,
  input wire logic                frame_irq_event_in,
  input wire logic                frame_err_event_in,
  input wire logic                cks_check_in,
  input wire logic                lin_enable_out,
  input wire logic                master_mode_out,
  input wire logic                auto_bit_rate_select_out,
  input wire logic                enhanced_cksum_out,
  input wire logic [3:0]          frame_length_out,
  input wire logic                irq_out,
  input wire logic                err_pending_out,
  input wire logic                bit_tick_out
);
  import lnsb_pkg::*;
  // ----------------------------------------
  // shadow of the timing registers
  // ----------------------------------------
  logic [7:0]  idx_ff, scale_ff, divl_ff;
  logic [19:0] gap_ff, tick_len;
  logic        seen_ff, rs_ff, win_wr, restart;
  assign win_wr = cpu_wr_in && cpu_sel_in == LNSB_SEL_WINDOW;
  assign restart = (cpu_wr_in && cpu_sel_in == LNSB_SEL_MODE) || !lin_enable_out
                   || (win_wr && (idx_ff == 8'h0c || idx_ff == 8'h0d));
  assign tick_len = (20'h2 << scale_ff[7:6])
                  * ({scale_ff[0], divl_ff} == 9'h0 ? 20'h200 : {11'h0, scale_ff[0], divl_ff})
                  * (auto_bit_rate_select_out ? 20'h1 : {15'h0, scale_ff[5:1]} + 20'h1);
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      idx_ff   <= 8'h00;
      scale_ff <= 8'h00;
      divl_ff  <= 8'h00;
    end else begin
      if (cpu_wr_in && cpu_sel_in == LNSB_SEL_INDEX) idx_ff <= cpu_wdata_in;
      if (win_wr && idx_ff == 8'h0d) scale_ff <= cpu_wdata_in;
      if (win_wr && idx_ff == 8'h0c) divl_ff <= cpu_wdata_in;
    end
  end
  // a tick one cycle after a restart may still come from the old setting
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      gap_ff  <= 20'h0;
      seen_ff <= 1'h0;
      rs_ff   <= 1'h0;
    end else begin
      gap_ff  <= bit_tick_out ? 20'h0 : gap_ff + 20'h1;
      rs_ff   <= restart;
      seen_ff <= (restart || rs_ff) ? 1'h0 : (seen_ff || bit_tick_out);
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!arst_n_in);
  sequence s_win_wr(logic [7:0] ix);
    win_wr && idx_ff == ix;
  endsequence
  sequence s_mode_wr;
    cpu_wr_in && cpu_sel_in == LNSB_SEL_MODE;
  endsequence
  AST_MODE_COPY: assert property (s_mode_wr |-> ##2
    {lin_enable_out, master_mode_out, auto_bit_rate_select_out} == $past(cpu_wdata_in[7:5], 2))
    else $error("mode outputs differ from written mode bits");
  AST_MODE_READ: assert property (cpu_rd_in && cpu_sel_in == LNSB_SEL_MODE
    |=> cpu_rdata_out[4:0] == 5'h00) else $error("unused mode bits read nonzero");
  AST_UNMAPPED: assert property (cpu_rd_in && cpu_sel_in == LNSB_SEL_WINDOW
    && !(idx_ff inside {8'h08, 8'h0b, 8'h0c, 8'h0d}) |=> cpu_rdata_out == 8'h00)
    else $error("unmapped window read nonzero");
  AST_SIZE_COPY: assert property (s_win_wr(8'h0b) |-> ##2
    enhanced_cksum_out == $past(cpu_wdata_in[7], 2)
    && frame_length_out == $past(cpu_wdata_in[3:0], 2)) else $error("checksum type not applied");
  AST_FLAG_CLR: assert property (s_win_wr(8'h08) ##0 (cpu_wdata_in[3:2] == 2'h3
    && !frame_irq_event_in && !frame_err_event_in && !cks_check_in)
    |-> ##2 !irq_out && !err_pending_out) else $error("flags not cleared");
  AST_EVENT_IRQ: assert property (frame_irq_event_in |-> ##2 irq_out)
    else $error("event gave no interrupt");
  AST_ERR_EVENT: assert property (frame_err_event_in |-> ##2 err_pending_out && irq_out)
    else $error("error event not pending");
  AST_TICK_PULSE: assert property (bit_tick_out |=> !bit_tick_out)
    else $error("tick longer than one cycle");
  AST_TICK_GAP: assert property (bit_tick_out && seen_ff |-> gap_ff == tick_len - 20'h1)
    else $error("bit time differs from programmed ratio");
endmodule

bind lnsb_top lnsb_top_props u_props (.clock_in, .arst_n_in, .cpu_sel_in, .cpu_wr_in,
  .cpu_rd_in, .cpu_wdata_in, .cpu_rdata_out, .frame_irq_event_in, .frame_err_event_in,
  .cks_check_in, .lin_enable_out, .master_mode_out, .auto_bit_rate_select_out,
  .enhanced_cksum_out, .frame_length_out, .irq_out, .err_pending_out, .bit_tick_out);

// *** tb/lnsb_frame_partner.sv ***
// far-side frame source: byte stream with its checksum and frame engine events
`timescale 1ns/1ps
module lnsb_frame_partner (
  input  wire logic  clock_in,
  output logic       clear_out,
  output logic [7:0] id_out,
  output logic       valid_out,
  output logic       check_out,
  output logic [7:0] byte_out,
  output logic       irq_ev_out,
  output logic       err_ev_out
);
  logic [7:0] data_q [3] = '{8'hf0, 8'h35, 8'h80};
  logic [8:0] sum;
  initial begin
    {clear_out, valid_out, check_out, irq_ev_out, err_ev_out} = 5'h00;
    id_out   = 8'h00;
    byte_out = 8'h00;
    sum      = 9'h000;
  end
  // idle lines show the inverse of the last value so stale data cannot pass
  task automatic send_frame(input logic enh, input logic [7:0] id);
    @(posedge clock_in);
    #1;
    clear_out = 1'h1;
    id_out    = id;
    sum       = enh ? {1'h0, id} : 9'h000;
    for (int i = 0; i < 3; i++) begin
      @(posedge clock_in);
      #1;
      clear_out = 1'h0;
      id_out    = ~id;
      valid_out = 1'h1;
      byte_out  = data_q[i];
      sum = {1'h0, sum[7:0]} + {1'h0, data_q[i]};
      sum = {1'h0, sum[7:0]} + {8'h00, sum[8]};
    end
    @(posedge clock_in);
    #1;
    valid_out = 1'h0;
    byte_out  = ~byte_out;
    repeat (3) @(posedge clock_in);
    #1;
  endtask
  task automatic send_check(input logic bad);
    @(posedge clock_in);
    #1;
    check_out = 1'h1;
    byte_out  = ~sum[7:0] ^ {7'h00, bad};
    @(posedge clock_in);
    #1;
    check_out = 1'h0;
    byte_out  = ~byte_out;
  endtask
  task automatic pulse(input logic irq, input logic err);
    @(posedge clock_in);
    #1;
    irq_ev_out = irq;
    err_ev_out = err;
    @(posedge clock_in);
    #1;
    irq_ev_out = 1'h0;
    err_ev_out = 1'h0;
  endtask
endmodule

// *** tb/test_lnsb_top.sv ***
// self-checking bench for the lin setup and bit-rate block
`timescale 1ns/1ps
module test_lnsb_top;
  import lnsb_pkg::*;
  logic       clock_in, arst_n_in, cpu_wr_in, cpu_rd_in, cks_clear_in, cks_byte_valid_in;
  logic       cks_check_in, cks_err_out, frame_irq_event_in, frame_err_event_in;
  logic       lin_enable_out, master_mode_out, auto_bit_rate_select_out, enhanced_cksum_out;
  logic       irq_out, err_pending_out, bit_tick_out;
  logic [7:0] cpu_wdata_in, cpu_rdata_out, cks_id_in, cks_byte_in, cks_value_out, frame_ctrl_out;
  logic [3:0] frame_length_out;
  lnsb_sel_t  cpu_sel_in;
  int         num_errors = 0;
  int         tests_run = 0;
  lnsb_top dut_u (.clock_in, .arst_n_in, .cpu_sel_in, .cpu_wr_in, .cpu_rd_in, .cpu_wdata_in,
    .cpu_rdata_out, .frame_irq_event_in, .frame_err_event_in, .cks_clear_in, .cks_id_in,
    .cks_byte_valid_in, .cks_check_in, .cks_byte_in, .cks_value_out, .cks_err_out,
    .lin_enable_out, .master_mode_out, .auto_bit_rate_select_out, .enhanced_cksum_out,
    .frame_ctrl_out, .frame_length_out, .irq_out, .err_pending_out, .bit_tick_out);
  lnsb_frame_partner u_far (.clock_in, .clear_out(cks_clear_in), .id_out(cks_id_in),
    .valid_out(cks_byte_valid_in), .check_out(cks_check_in), .byte_out(cks_byte_in),
    .irq_ev_out(frame_irq_event_in), .err_ev_out(frame_err_event_in));
  // 10 MHz keeps the core clock above the controller's minimum
  initial begin
    clock_in = 1'h0;
    forever #50 clock_in = ~clock_in;
  end
  // ----------------------------------------
  // access and compare tasks
  // ----------------------------------------
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic acc(input lnsb_sel_t s, input logic w, input logic [7:0] d);
    @(posedge clock_in);
    #1;
    cpu_sel_in   = s;
    cpu_wr_in    = w;
    cpu_rd_in    = !w;
    cpu_wdata_in = d;
    @(posedge clock_in);
    #1;
    cpu_wr_in  = 1'h0;
    cpu_rd_in  = 1'h0;
    cpu_sel_in = LNSB_SEL_NONE;
  endtask
  task automatic rd(input lnsb_sel_t s, input logic [7:0] e);
    acc(s, 1'h0, 8'h00);
    chk(cpu_rdata_out, e);
  endtask
  task automatic wri(input logic [7:0] i, input logic [7:0] d);
    acc(LNSB_SEL_INDEX, 1'h1, i);
    acc(LNSB_SEL_WINDOW, 1'h1, d);
  endtask
  task automatic rdi(input logic [7:0] i, input logic [7:0] e);
    acc(LNSB_SEL_INDEX, 1'h1, i);
    rd(LNSB_SEL_WINDOW, e);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  task automatic period(input logic [31:0] exp);
    int n;
    int w;
    n = 0;
    w = 0;
    // both waits are bounded; a missing tick on either side is a mismatch
    while (bit_tick_out !== 1'h1 && w < 6000) begin
      idle(1);
      w++;
    end
    do begin
      idle(1);
      n++;
    end while (bit_tick_out !== 1'h1 && n < 6000);
    if (w >= 6000 || n >= 6000) begin
      num_errors++;
      end_sim();
    end
    chk(n, exp);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    arst_n_in = 1'h0;
    cpu_sel_in = LNSB_SEL_NONE;
    {cpu_wr_in, cpu_rd_in, cpu_wdata_in} = 10'h000;
    repeat (3) @(posedge clock_in);
    #1;
    arst_n_in = 1'h1;
    idle(3);
    rd(LNSB_SEL_MODE, 8'h00);
    chk(cks_value_out, 8'hff);
    rdi(8'h08, 8'h00);
    $display("reset test done");
    acc(LNSB_SEL_MODE, 1'h1, 8'hbf); // auto only with slave
    rd(LNSB_SEL_MODE, 8'ha0);
    chk({lin_enable_out, master_mode_out, auto_bit_rate_select_out}, 3'h5);
    wri(8'h05, 8'h55);
    rdi(8'h05, 8'h00);
    rd(LNSB_SEL_NONE, 8'h00);
    $display("register test done");
    acc(LNSB_SEL_MODE, 1'h1, 8'hc0); // master keeps manual timing
    wri(8'h0c, 8'h00);
    wri(8'h0d, 8'h43);
    rdi(8'h0d, 8'h43);
    chk(master_mode_out, 1'h1);
    period(2048);
    acc(LNSB_SEL_MODE, 1'h1, 8'ha0);
    wri(8'h0d, 8'h02);
    wri(8'h0c, 8'hc8);
    period(400);
    acc(LNSB_SEL_MODE, 1'h1, 8'h80);
    wri(8'h0d, 8'h02);
    period(800);
    $display("bit rate test done");
    wri(8'h0b, 8'h03);
    idle(1);
    chk({enhanced_cksum_out, frame_length_out}, 5'h03);
    u_far.send_frame(1'h0, 8'h8e);
    chk(cks_value_out, 8'h59);
    u_far.send_check(1'h0);
    idle(2);
    chk({cks_err_out, err_pending_out}, 2'h0);
    wri(8'h0b, 8'h83);
    u_far.send_frame(1'h1, 8'h8e);
    chk(cks_value_out, 8'hca);
    u_far.send_check(1'h1);
    idle(2);
    chk({cks_err_out, err_pending_out, irq_out}, 3'h7);
    rdi(8'h08, 8'h0c);
    $display("checksum test done");
    wri(8'h08, 8'h0c);
    idle(1);
    chk({irq_out, err_pending_out}, 2'h0);
    u_far.pulse(1'h1, 1'h0);
    idle(1);
    chk(irq_out, 1'h1);
    wri(8'h08, 8'h31);
    idle(1);
    chk(frame_ctrl_out, 8'h31);
    rdi(8'h08, 8'h39);
    u_far.pulse(1'h0, 1'h1);
    wri(8'h08, 8'h08);
    idle(1);
    chk({irq_out, err_pending_out}, 2'h1);
    rdi(8'h08, 8'h04);
    $display("flag test done");
    end_sim();
  end
endmodule
